// ### common/radio_ovr_pkg.sv
// Purpose: Constants and carriers for the radio override and calibration register bank
// Assumes: 7-bit register addresses delivered by the chip's serial front end
// Notes:   All offsets, field positions and reset values live here
package radio_ovr_pkg;

   // Register addresses
   localparam logic [6:0] ADDR_SYNTH_OVR  = 7'h5f;
   localparam logic [6:0] ADDR_COEF_ADDR  = 7'h60;
   localparam logic [6:0] ADDR_COEF_VALUE = 7'h61;
   localparam logic [6:0] ADDR_XTAL_CTRL  = 7'h62;
   localparam logic [6:0] ADDR_RC_COARSE  = 7'h63;
   localparam logic [6:0] ADDR_RC_FINE    = 7'h64;

   // Reset values
   localparam logic [7:0] RST_SYNTH_OVR   = 8'h00;
   localparam logic [3:0] RST_COEF_ADDR   = 4'h0;
   localparam logic [5:0] RST_COEF_VALUE  = 6'h00;
   localparam logic [4:0] RST_XTAL_CTRL   = 5'h04;
   localparam logic [7:0] RST_RC_COARSE   = 8'h00;
   localparam logic [7:0] RST_RC_FINE     = 8'h00;
   localparam logic [7:0] READ_ZERO       = 8'h00;

   // Synthesizer override bit positions
   localparam int SYN_FRAC_DIV        = 7;
   localparam int SYN_DIV_THREE_ONE   = 6;
   localparam int SYN_DIV_TWO         = 5;
   localparam int SYN_DIV_ONE_HALF    = 4;
   localparam int SYN_VCO_BIAS_SHUNT  = 3;
   localparam int SYN_VCO             = 2;
   localparam int SYN_CHARGE_PUMP     = 1;
   localparam int SYN_BANDGAP         = 0;

   // Oscillator control field positions
   localparam int XT_PWST_HI          = 7;
   localparam int XT_PWST_LO          = 5;
   localparam int XT_CLK_HYST         = 4;
   localparam int XT_DOUBLE_BIAS      = 3;
   localparam int XT_DOUBLE_AMP       = 2;
   localparam int XT_BUF_OVR          = 1;
   localparam int XT_BUF_EN           = 0;

   // Calibration register layout
   localparam int CAL_OVR_BIT         = 7;
   localparam int CAL_VAL_HI          = 6;
   localparam int COEF_ADDR_HI        = 3;
   localparam int COEF_VAL_HI         = 5;
   localparam int COEF_DEPTH          = 16;

   // Power state encodings
   localparam logic [2:0] PWST_LOW_POWER = 3'h0;
   localparam logic [2:0] PWST_READY     = 3'h1;
   localparam logic [2:0] PWST_TUNE      = 3'h3;
   localparam logic [2:0] PWST_TRANSMIT  = 3'h2;
   localparam logic [2:0] PWST_RECEIVE   = 3'h7;

   // One register access from the serial front end
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   // Values reported by the calibration engines and the chip state machine
   typedef struct packed {
      logic [2:0] power_state;
      logic       sm_xtal_buf_en;
      logic [6:0] rc_coarse;
      logic [6:0] rc_fine;
   } chip_status_s;

endpackage : radio_ovr_pkg

// ### rtl/coef_lut.sv
// Purpose: Channel filter coefficient table, one host port and one filter read port
// Assumes: Host write and filter read share the clock
// Notes:   Host read is combinational; the caller registers it
module coef_lut (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Host port
   input  wire logic [3:0] host_addr_i,
   input  wire logic       host_wr_i,
   input  wire logic [5:0] host_wdata_i,
   output logic      [5:0] host_rdata_o,
   // Filter port
   input  wire logic [3:0] filt_addr_i,
   output logic      [5:0] filt_rdata_o
);

   logic [5:0] table_mem [radio_ovr_pkg::COEF_DEPTH];

   // Kept in flops with reset so the filter never sees an undefined tap
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < radio_ovr_pkg::COEF_DEPTH; i++) begin
            table_mem[i] <= radio_ovr_pkg::RST_COEF_VALUE;
         end
      end else if (host_wr_i) begin
         table_mem[host_addr_i] <= host_wdata_i;
      end
   end

   assign host_rdata_o = table_mem[host_addr_i];

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         filt_rdata_o <= radio_ovr_pkg::RST_COEF_VALUE;
      end else begin
         filt_rdata_o <= table_mem[filt_addr_i];
      end
   end

endmodule : coef_lut

// ### rtl/radio_ovr_regs.sv
// Purpose: Synthesizer override, coefficient window, crystal and RC calibration registers
// Assumes: Register accesses and status come from logic on clk_i
// Notes:   Block outputs follow a register write by two clock edges

module radio_ovr_regs (
   // Clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   // Register access
   input  wire radio_ovr_pkg::reg_req_s    req_i,
   output logic                      [7:0] rdata_o,
   output logic                            rvalid_o,
   // Chip status and state machine enables
   input  wire radio_ovr_pkg::chip_status_s status_i,
   input  wire logic                 [7:0] sm_synth_en_i,
   input  wire logic                       global_override_en_i,
   // Synthesizer block enables
   output logic                      [7:0] synth_en_o,
   // Crystal oscillator controls
   output logic                            xtal_buf_en_o,
   output logic                            xtal_clk_hyst_o,
   output logic                            double_bias_current_o,
   output logic                            double_amplification_o,
   // RC oscillator calibration in use
   output logic                      [6:0] rc_coarse_o,
   output logic                      [6:0] rc_fine_o,
   // Channel filter tap readout
   input  wire logic                 [3:0] filt_coef_addr_i,
   output logic                      [5:0] filt_coef_o
);

   logic [7:0] synth_ovr_reg;
   logic [3:0] coef_addr_reg;
   logic [4:0] xtal_ctrl_reg;
   logic [7:0] rc_coarse_reg;
   logic [7:0] rc_fine_reg;
   logic [5:0] coef_host_rdata;
   logic       coef_wr;
   logic [7:0] rdata_next;
   logic [7:0] synth_en_next;
   logic [6:0] coarse_eff;
   logic [6:0] fine_eff;

   // Override select shared by both calibration paths
   function automatic logic [6:0] ovr_sel(input logic       ovr,
                                          input logic [6:0] sw_val,
                                          input logic [6:0] int_val);
      ovr_sel = ovr ? sw_val : int_val;
   endfunction : ovr_sel

   // Write decode for one register address
   function automatic logic hit(input radio_ovr_pkg::reg_req_s r, input logic [6:0] a);
      hit = r.wr && (r.addr == a);
   endfunction : hit

   // Synthesizer override register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         synth_ovr_reg <= radio_ovr_pkg::RST_SYNTH_OVR;
      end else if (hit(req_i, radio_ovr_pkg::ADDR_SYNTH_OVR)) begin
         synth_ovr_reg <= req_i.wdata;
      end
   end

   // Coefficient address; reserved bits are not stored
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         coef_addr_reg <= radio_ovr_pkg::RST_COEF_ADDR;
      end else if (hit(req_i, radio_ovr_pkg::ADDR_COEF_ADDR)) begin
         coef_addr_reg <= req_i.wdata[radio_ovr_pkg::COEF_ADDR_HI:0];
      end
   end

   assign coef_wr = hit(req_i, radio_ovr_pkg::ADDR_COEF_VALUE);

   // Table kept outside the read mux so the filter port never waits on the host
   coef_lut coef_lut_inst (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .host_addr_i  (coef_addr_reg),
      .host_wr_i    (coef_wr),
      .host_wdata_i (req_i.wdata[radio_ovr_pkg::COEF_VAL_HI:0]),
      .host_rdata_o (coef_host_rdata),
      .filt_addr_i  (filt_coef_addr_i),
      .filt_rdata_o (filt_coef_o)
   );

   // Oscillator control, writable low five bits only
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         xtal_ctrl_reg <= radio_ovr_pkg::RST_XTAL_CTRL;
      end else if (hit(req_i, radio_ovr_pkg::ADDR_XTAL_CTRL)) begin
         xtal_ctrl_reg <= req_i.wdata[radio_ovr_pkg::XT_CLK_HYST:0];
      end
   end

   // Calibration registers: flag in bit 7, value below
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rc_coarse_reg <= radio_ovr_pkg::RST_RC_COARSE;
      end else if (hit(req_i, radio_ovr_pkg::ADDR_RC_COARSE)) begin
         rc_coarse_reg <= req_i.wdata;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rc_fine_reg <= radio_ovr_pkg::RST_RC_FINE;
      end else if (hit(req_i, radio_ovr_pkg::ADDR_RC_FINE)) begin
         rc_fine_reg <= req_i.wdata;
      end
   end

   // Value in use is also what software reads back
   assign coarse_eff = ovr_sel(rc_coarse_reg[radio_ovr_pkg::CAL_OVR_BIT],
                               rc_coarse_reg[radio_ovr_pkg::CAL_VAL_HI:0],
                               status_i.rc_coarse);
   assign fine_eff   = ovr_sel(rc_fine_reg[radio_ovr_pkg::CAL_OVR_BIT],
                               rc_fine_reg[radio_ovr_pkg::CAL_VAL_HI:0],
                               status_i.rc_fine);

   // Without the global enable an override bit can only add an enable
   always_comb begin
      if (global_override_en_i) begin
         synth_en_next = synth_ovr_reg;
      end else begin
         synth_en_next = synth_ovr_reg | sm_synth_en_i;
      end
   end

   // Registered so a block enable never glitches while the override is written
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         synth_en_o <= radio_ovr_pkg::RST_SYNTH_OVR;
      end else begin
         synth_en_o <= synth_en_next;
      end
   end

   // Crystal oscillator outputs
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         xtal_buf_en_o          <= 1'b0;
         xtal_clk_hyst_o        <= radio_ovr_pkg::RST_XTAL_CTRL[radio_ovr_pkg::XT_CLK_HYST];
         double_bias_current_o  <= radio_ovr_pkg::RST_XTAL_CTRL[radio_ovr_pkg::XT_DOUBLE_BIAS];
         double_amplification_o <= radio_ovr_pkg::RST_XTAL_CTRL[radio_ovr_pkg::XT_DOUBLE_AMP];
      end else begin
         // Software enable is dead unless the override bit is set
         xtal_buf_en_o <= xtal_ctrl_reg[radio_ovr_pkg::XT_BUF_OVR] ?
                          xtal_ctrl_reg[radio_ovr_pkg::XT_BUF_EN] :
                          status_i.sm_xtal_buf_en;
         xtal_clk_hyst_o        <= xtal_ctrl_reg[radio_ovr_pkg::XT_CLK_HYST];
         double_bias_current_o  <= xtal_ctrl_reg[radio_ovr_pkg::XT_DOUBLE_BIAS];
         double_amplification_o <= xtal_ctrl_reg[radio_ovr_pkg::XT_DOUBLE_AMP];
      end
   end

   // Calibration values handed to the RC oscillator
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rc_coarse_o <= radio_ovr_pkg::RST_RC_COARSE[radio_ovr_pkg::CAL_VAL_HI:0];
         rc_fine_o   <= radio_ovr_pkg::RST_RC_FINE[radio_ovr_pkg::CAL_VAL_HI:0];
      end else begin
         rc_coarse_o <= coarse_eff;
         rc_fine_o   <= fine_eff;
      end
   end

   // Read mux; unmapped addresses return zero
   always_comb begin
      rdata_next = radio_ovr_pkg::READ_ZERO;
      unique case (req_i.addr)
         radio_ovr_pkg::ADDR_SYNTH_OVR: begin
            rdata_next = synth_ovr_reg;
         end
         radio_ovr_pkg::ADDR_COEF_ADDR: begin
            rdata_next[radio_ovr_pkg::COEF_ADDR_HI:0] = coef_addr_reg;
         end
         radio_ovr_pkg::ADDR_COEF_VALUE: begin
            rdata_next[radio_ovr_pkg::COEF_VAL_HI:0] = coef_host_rdata;
         end
         radio_ovr_pkg::ADDR_XTAL_CTRL: begin
            // Power state is sampled live, never latched
            rdata_next[radio_ovr_pkg::XT_PWST_HI:radio_ovr_pkg::XT_PWST_LO] =
               status_i.power_state;
            rdata_next[radio_ovr_pkg::XT_CLK_HYST:0] = xtal_ctrl_reg;
         end
         radio_ovr_pkg::ADDR_RC_COARSE: begin
            rdata_next = {rc_coarse_reg[radio_ovr_pkg::CAL_OVR_BIT], coarse_eff};
         end
         radio_ovr_pkg::ADDR_RC_FINE: begin
            rdata_next = {rc_fine_reg[radio_ovr_pkg::CAL_OVR_BIT], fine_eff};
         end
         default: begin
            rdata_next = radio_ovr_pkg::READ_ZERO;
         end
      endcase
   end

   // Read data holds between reads; the valid flag pulses once per read strobe
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o  <= radio_ovr_pkg::READ_ZERO;
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= req_i.rd;
         if (req_i.rd) begin
            rdata_o <= rdata_next;
         end
      end
   end

endmodule : radio_ovr_regs

// ### dv/radio_ovr_regs_props.sv
// Purpose: Port assertions for the override and calibration register bank
// Assumes: One clock, asynchronous reset active high
// Notes:   Readback is used as a window on stored values
module radio_ovr_regs_props (
   // Clock and reset
   input wire logic                         clk_i,
   input wire logic                         rst_i,
   // Inputs watched
   input wire radio_ovr_pkg::reg_req_s      req_i,
   input wire radio_ovr_pkg::chip_status_s  status_i,
   input wire logic                   [7:0] sm_synth_en_i,
   input wire logic                         global_override_en_i,
   // Outputs watched
   input wire logic                   [7:0] rdata_o,
   input wire logic                         rvalid_o,
   input wire logic                   [7:0] synth_en_o,
   input wire logic                         xtal_buf_en_o,
   input wire logic                         xtal_clk_hyst_o,
   input wire logic                         double_bias_current_o,
   input wire logic                         double_amplification_o,
   input wire logic                   [6:0] rc_coarse_o,
   input wire logic                   [6:0] rc_fine_o
);
   wire logic rdx = req_i.rd && req_i.addr == radio_ovr_pkg::ADDR_XTAL_CTRL;
   wire logic rdc = req_i.rd && req_i.addr == radio_ovr_pkg::ADDR_RC_COARSE;
   wire logic rdf = req_i.rd && req_i.addr == radio_ovr_pkg::ADDR_RC_FINE;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_read_answer: assert property (req_i.rd |=> rvalid_o)
      else $error("read not answered");
   a_synth_write: assert property (
      req_i.wr && req_i.addr == radio_ovr_pkg::ADDR_SYNTH_OVR ##1 global_override_en_i
      |=> synth_en_o == $past(req_i.wdata, 2)) else $error("synth enables miss write");
   a_synth_force_on: assert property (
      !global_override_en_i |=> (synth_en_o & $past(sm_synth_en_i)) == $past(sm_synth_en_i))
      else $error("state machine enable lost");
   a_pwst_live: assert property (
      rdx |=> rdata_o[7:5] == $past(status_i.power_state)) else $error("power state stale");
   a_xtal_bits: assert property (
      rdx |=> {xtal_clk_hyst_o, double_bias_current_o, double_amplification_o} == rdata_o[4:2])
      else $error("oscillator bits differ");
   a_buf_select: assert property (
      rdx |=> xtal_buf_en_o == (rdata_o[1] ? rdata_o[0] : $past(status_i.sm_xtal_buf_en)))
      else $error("buffer enable source wrong");
   a_coarse_use: assert property (rdc |=> rc_coarse_o == rdata_o[6:0])
      else $error("coarse value in use differs");
   a_fine_use: assert property (rdf |=> rc_fine_o == rdata_o[6:0])
      else $error("fine value in use differs");
   a_coarse_view: assert property (
      rdc |=> rdata_o[7] || rdata_o[6:0] == $past(status_i.rc_coarse))
      else $error("coarse result not shown");
   a_fine_view: assert property (
      rdf |=> rdata_o[7] || rdata_o[6:0] == $past(status_i.rc_fine))
      else $error("fine result not shown");
endmodule : radio_ovr_regs_props

// ### dv/reg_host.sv
// Purpose: Host side model of the register access port
// Assumes: Calls are made just after a rising edge
// Notes:   A write strobe left high repeats, so callers idle after a burst
module reg_host (
   // Clock
   input  wire logic                clk_i,
   // Register request
   output radio_ovr_pkg::reg_req_s  req_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial req_o = '0;
   // Request held until the edge that takes it
   task automatic acc(input logic w, input logic r, input logic [6:0] a,
                      input logic [7:0] d);
      req_o <= '{wr: w, rd: r, addr: a, wdata: d};
      @(posedge clk_i);
   endtask : acc
   // Released lines stop showing the last value
   task automatic idle();
      req_o.wr <= 1'b0;
      req_o.rd <= 1'b0;
      req_o.addr <= ~req_o.addr;
      req_o.wdata <= ~req_o.wdata;
   endtask : idle
endmodule : reg_host

// ### dv/test_radio_ovr_regs.sv
// Purpose: Self-checking bench for the override and calibration register bank
// Assumes: Host model drives requests, bench drives chip status
// Notes:   Read answers are checked in order against queued expectations
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
   $display("mismatch at %0t: got %h want %h", $time, a, e); end end
module test_radio_ovr_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   radio_ovr_pkg::reg_req_s req;
   radio_ovr_pkg::chip_status_s st;
   logic [7:0] sm_en, rdata, synth_en, w, e, q;
   logic glob, rvalid, buf_en, hyst, bias, amp;
   logic [6:0] coarse, fine;
   logic [3:0] faddr;
   logic [5:0] fcoef;
   logic [5:0] tbl[16];
   logic [7:0] expq[$];
   logic [2:0] pw[5] = '{radio_ovr_pkg::PWST_LOW_POWER, radio_ovr_pkg::PWST_READY,
      radio_ovr_pkg::PWST_TUNE, radio_ovr_pkg::PWST_TRANSMIT, radio_ovr_pkg::PWST_RECEIVE};
   int n_fail = 0;
   int tests_run = 0;
   always #20 clk_i = ~clk_i;
   reg_host reg_host_inst (.clk_i(clk_i), .req_o(req));
   radio_ovr_regs radio_ovr_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
      .rdata_o(rdata), .rvalid_o(rvalid), .status_i(st), .sm_synth_en_i(sm_en),
      .global_override_en_i(glob), .synth_en_o(synth_en), .xtal_buf_en_o(buf_en),
      .xtal_clk_hyst_o(hyst), .double_bias_current_o(bias), .double_amplification_o(amp),
      .rc_coarse_o(coarse), .rc_fine_o(fine), .filt_coef_addr_i(faddr), .filt_coef_o(fcoef));
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      reg_host_inst.acc(1'b1, 1'b0, a, d);
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [7:0] x);
      expq.push_back(x);
      reg_host_inst.acc(1'b0, 1'b1, a, 8'h00);
   endtask : rd
   task automatic idle(input int n);
      reg_host_inst.idle();
      repeat (n) @(posedge clk_i);
   endtask : idle
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test
   // Sampled mid-cycle, away from the edge that launches the answer
   always @(negedge clk_i) begin
      if (rvalid === 1'b1) begin
         q = expq.pop_front();
         `CHK(rdata, q)
      end
   end
   initial begin
      #400000;
      n_fail++;
      stop_test();
   end
   initial begin
      void'($urandom(53));
      st = '0;
      sm_en = '0;
      glob = 1'b1;
      faddr = '0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      st <= 18'($urandom);
      @(posedge clk_i);
      rd(radio_ovr_pkg::ADDR_SYNTH_OVR, 8'h00);
      rd(radio_ovr_pkg::ADDR_COEF_VALUE, 8'h00);
      rd(radio_ovr_pkg::ADDR_XTAL_CTRL, {st.power_state, 5'h04});
      rd(radio_ovr_pkg::ADDR_RC_COARSE, {1'b0, st.rc_coarse});
      rd(radio_ovr_pkg::ADDR_RC_FINE, {1'b0, st.rc_fine});
      rd(7'h65, 8'h00);
      // Back-to-back state changes, each read straight away
      foreach (pw[i]) begin
         st.power_state <= pw[i];
         rd(radio_ovr_pkg::ADDR_XTAL_CTRL, {pw[i], 5'h04});
      end
      w = 8'($urandom);
      sm_en <= 8'($urandom);
      wr(radio_ovr_pkg::ADDR_SYNTH_OVR, w);
      rd(radio_ovr_pkg::ADDR_SYNTH_OVR, w);
      idle(2);
      `CHK(synth_en, w)
      glob <= 1'b0;
      idle(2);
      `CHK(synth_en, w | sm_en)
      glob <= 1'b1;
      // Reserved bits written as ones on purpose to see them dropped
      for (int i = 0; i < 16; i++) begin
         tbl[i] = 6'($urandom);
         wr(radio_ovr_pkg::ADDR_COEF_ADDR, {4'hf, 4'(i)});
         wr(radio_ovr_pkg::ADDR_COEF_VALUE, {2'b11, tbl[i]});
         rd(radio_ovr_pkg::ADDR_COEF_VALUE, {2'b00, tbl[i]});
      end
      for (int i = 15; i >= 0; i--) begin
         wr(radio_ovr_pkg::ADDR_COEF_ADDR, 8'(i));
         rd(radio_ovr_pkg::ADDR_COEF_ADDR, 8'(i));
         rd(radio_ovr_pkg::ADDR_COEF_VALUE, {2'b00, tbl[i]});
         faddr <= 4'(i);
         idle(2);
         `CHK(fcoef, tbl[i])
      end
      for (int k = 0; k < 4; k++) begin
         w = 8'($urandom);
         w[1:0] = 2'(k);
         st.sm_xtal_buf_en <= ~w[0];
         wr(radio_ovr_pkg::ADDR_XTAL_CTRL, w);
         rd(radio_ovr_pkg::ADDR_XTAL_CTRL, {st.power_state, w[4:0]});
         idle(2);
         `CHK(buf_en, w[1] ? w[0] : ~w[0])
         `CHK({hyst, bias, amp}, w[4:2])
      end
      for (int k = 0; k < 4; k++) begin
         w = {k[0], 7'($urandom)};
         e = {k[1], 7'($urandom)};
         st.rc_coarse <= 7'($urandom);
         st.rc_fine <= 7'($urandom);
         wr(radio_ovr_pkg::ADDR_RC_COARSE, w);
         wr(radio_ovr_pkg::ADDR_RC_FINE, e);
         rd(radio_ovr_pkg::ADDR_RC_COARSE, w[7] ? w : {1'b0, st.rc_coarse});
         rd(radio_ovr_pkg::ADDR_RC_FINE, e[7] ? e : {1'b0, st.rc_fine});
         idle(2);
         `CHK(coarse, w[7] ? w[6:0] : st.rc_coarse)
         `CHK(fine, e[7] ? e[6:0] : st.rc_fine)
      end
      idle(3);
      `CHK(expq.size(), 0)
      stop_test();
   end
endmodule : test_radio_ovr_regs
bind radio_ovr_regs radio_ovr_regs_props radio_ovr_regs_props_inst (.clk_i(clk_i),
   .rst_i(rst_i), .req_i(req_i), .status_i(status_i), .sm_synth_en_i(sm_synth_en_i),
   .global_override_en_i(global_override_en_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
   .synth_en_o(synth_en_o), .xtal_buf_en_o(xtal_buf_en_o), .xtal_clk_hyst_o(xtal_clk_hyst_o),
   .double_bias_current_o(double_bias_current_o), .rc_coarse_o(rc_coarse_o),
   .double_amplification_o(double_amplification_o), .rc_fine_o(rc_fine_o));
